/* hw/tsi_conn_dev.sv */
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "tsi_params.svh"
module tsi_conn_dev import tsi_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // register link from the host
  tsi_if.dev              dif,
  // local stream rate
  input  wire logic [1:0] rate_sel,
  // local output slot timing and data memory
  input  wire logic       slot_tick,
  input  wire logic [9:0] cur_addr,
  output logic      [9:0] dm_addr,
  input  wire logic [7:0] dm_data,
  output logic      [7:0] line_data,
  output logic            line_oe,
  output logic            line_buf_sel,
  output logic            aux_strobe,
  // bus side slot timing and match result
  input  wire logic       bus_tick,
  input  wire logic [4:0] bus_stream,
  input  wire logic [6:0] bus_slot,
  output logic            cam_hit,
  output logic            cam_write,
  output logic            cam_pattern,
  output logic            cam_buf_sel,
  output logic      [8:0] cam_tag,
  // status
  output logic            cam_full,
  output logic            cfg_err
);

  dev_s q, n;

  function automatic logic [9:0] phys(input logic [3:0] s, input logic [6:0] t,
                                      input logic [1:0] r);
    case (r)
      `RATE_2M: phys = {1'b0, s, t[4:0]};
      `RATE_4M: phys = {s, t[5:0]};
      default:  phys = {s[2:0], t};
    endcase
  endfunction

  function automatic logic slot_ok(input logic [6:0] t, input logic [1:0] r);
    case (r)
      `RATE_2M: slot_ok = (t <= `MAX_2M);
      `RATE_4M: slot_ok = (t <= `MAX_4M);
      default:  slot_ok = (t <= `MAX_8M);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    lcl_ent_s   e;
    lcl_ent_s   en;
    lcl_ent_s   w;
    logic [8:0] free_idx;
    logic [8:0] hit_idx;
    logic [8:0] brk_idx;
    logic       free_ok;
    logic       hit_ok;
    logic       brk_ok;
    logic       pat_w;
    n        = q;
    e        = q.cmem[cur_addr];
    en       = q.cmem[10'(cur_addr + 10'h001)];
    w        = '0;
    free_idx = 9'h000;
    hit_idx  = 9'h000;
    brk_idx  = 9'h000;
    free_ok  = 1'b0;
    hit_ok   = 1'b0;
    brk_ok   = 1'b0;
    pat_w    = dif.wdata[`B_PAT];

    // descending scan so the lowest index wins
    for (int i = 511; i >= 0; i--) begin
      if (!q.assoc_connection_block[i].v) begin
        free_ok  = 1'b1;
        free_idx = 9'(i);
      end
      if (q.assoc_connection_block[i].v && q.assoc_connection_block[i].slot == bus_slot && q.assoc_connection_block[i].strm == bus_stream) begin
        hit_ok  = 1'b1;
        hit_idx = 9'(i);
      end
      if (q.assoc_connection_block[i].v && q.assoc_connection_block[i].slot == q.h_slot[6:0] &&
          q.assoc_connection_block[i].strm == q.h_cs[4:0]) begin
        brk_ok  = 1'b1;
        brk_idx = 9'(i);
      end
    end
    n.full = !free_ok;

    // read path first so that an error raised by a write in the same cycle survives
    if (dif.rd) begin
      case (dif.sel)
        `SEL_LOW:  n.rdata = q.low_addr;
        `SEL_MODE: n.rdata = q.mode;
        `SEL_DATA: begin
          if (q.mode == `CMD_QLO || q.mode == `CMD_QHI) begin
            n.rdata = q.rd_hi ? {7'h00, q.qword.tag[8]} : q.qword.tag[7:0];
            n.rd_hi = !q.rd_hi;
          end else begin
            n.rdata = q.lo_hold;
          end
        end
        default: begin
          n.rdata = {q.err, q.full, 6'h00};
          n.err   = 1'b0;
        end
      endcase
    end

    if (dif.wr) begin
      case (dif.sel)
        `SEL_LOW:  n.low_addr = dif.wdata;
        `SEL_MODE: n.mode     = dif.wdata;
        `SEL_DATA: begin
          if (q.mode[7:4] == `FLD_LO) begin
            n.lo_hold = dif.wdata;
          end else if (q.mode[7:4] == `FLD_HI) begin
            w.aux  = dif.wdata[`B_AUX];
            w.pat  = pat_w;
            w.alt  = dif.wdata[`B_ALT];
            w.ena  = dif.wdata[`B_ENA];
            w.strm = dif.wdata[3:0];
            w.slot = q.lo_hold[6:0];
            if (pat_w) begin
              w.strm[0] = q.lo_hold[7];
            end
            if (slot_ok(q.low_addr[6:0], rate_sel) &&
                (pat_w || slot_ok(q.lo_hold[6:0], rate_sel))) begin
              n.cmem[phys(q.mode[3:0], q.low_addr[6:0], rate_sel)] = w;
            end else begin
              n.err = 1'b1;
            end
          end else if (q.mode[7:4] == `HOLD_GRP) begin
            case (q.mode[1:0])
              `HOLD_SLOT: n.h_slot = dif.wdata;
              `HOLD_CS:   n.h_cs   = dif.wdata;
              `HOLD_TAG:  n.h_tag  = dif.wdata;
              default:    n.h_sub  = dif.wdata;
            endcase
          end else if (dif.wdata != q.mode) begin
            n.err = 1'b1;
          end else begin
            case (q.mode)
              `CMD_MAKE: begin
                if (free_ok) begin
                  n.assoc_connection_block[free_idx].v    = 1'b1;
                  n.assoc_connection_block[free_idx].slot = q.h_slot[6:0];
                  n.assoc_connection_block[free_idx].strm = q.h_cs[4:0];
                  n.assoc_connection_block[free_idx].rw   = q.h_cs[`B_AUX];
                  n.assoc_connection_block[free_idx].pat  = q.h_cs[`B_PAT];
                  n.assoc_connection_block[free_idx].alt  = q.h_cs[`B_ALT];
                  n.assoc_connection_block[free_idx].tag  = {q.h_sub[0], q.h_tag};
                  n.assoc_connection_block[free_idx].sub  = q.h_sub[7:1];
                end else begin
                  n.err = 1'b1;
                end
              end
              `CMD_BREAK: begin
                if (brk_ok) begin
                  n.assoc_connection_block[brk_idx].v = 1'b0;
                end else begin
                  n.err = 1'b1;
                end
              end
              `CMD_QLO, `CMD_QHI: begin
                n.qword = q.assoc_connection_block[{q.mode[0], q.low_addr}];
                n.rd_hi = 1'b0;
              end
              default: n.err = 1'b1;
            endcase
          end
        end
        default: ;
      endcase
    end

    // local output: entry of the coming slot, aux from the slot after it
    if (slot_tick) begin
      n.aux     = en.aux;
      n.oe      = e.ena;
      n.bufsel  = e.alt;
      n.pat     = e.pat;
      n.patb    = {e.strm[0], e.slot};
      n.dm_addr = phys(e.strm, e.slot, rate_sel);
    end
    n.line = q.pat ? q.patb : dm_data;

    if (bus_tick) begin
      n.hit  = hit_ok;
      n.cdir = q.assoc_connection_block[hit_idx].rw;
      n.cpat = q.assoc_connection_block[hit_idx].pat;
      n.cbuf = q.assoc_connection_block[hit_idx].alt;
      n.ctag = q.assoc_connection_block[hit_idx].tag;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dif.rdata    = q.rdata;
  assign dm_addr      = q.dm_addr;
  assign line_data    = q.line;
  assign line_oe      = q.oe;
  assign line_buf_sel = q.bufsel;
  assign aux_strobe   = q.aux;
  assign cam_hit      = q.hit;
  assign cam_write    = q.cdir;
  assign cam_pattern  = q.cpat;
  assign cam_buf_sel  = q.cbuf;
  assign cam_tag      = q.ctag;
  assign cam_full     = q.full;
  assign cfg_err      = q.err;

endmodule // tsi_conn_dev

/* hw/tsi_conn_host.sv */
`timescale 1ns/1ns
`include "tsi_params.svh"
module tsi_conn_host import tsi_pkg::*; (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // avalon-mm slave for software
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  output logic      [31:0] av_readdata,
  output logic             av_waitrequest,
  // register link to the device
  tsi_if.host              dif
);

  host_s q, n;

  // returns {last, select, data} of one step of the programming sequence
  function automatic logic [10:0] seq_word(input host_s h);
    logic [7:0] src_lo;
    src_lo = h.ctl[`B_PAT] ? h.src[7:0] : {1'b0, h.src[6:0]};
    seq_word = {1'b1, `SEL_STAT, 8'h00};
    if (h.op == `OP_LOCAL) begin
      case (h.step)
        4'h0: seq_word = {1'b0, `SEL_LOW, 1'b0, h.dest[6:0]};
        4'h1: seq_word = {1'b0, `SEL_MODE, `FLD_LO, h.dest[10:7]};
        4'h2: seq_word = {1'b0, `SEL_DATA, src_lo};
        4'h3: seq_word = {1'b0, `SEL_MODE, `FLD_HI, h.dest[10:7]};
        default: seq_word = {1'b1, `SEL_DATA, h.ctl[7:4], h.src[10:7]};
      endcase
    end else begin
      case (h.step)
        4'h0: seq_word = {1'b0, `SEL_MODE, `HOLD_GRP, 2'h0, `HOLD_SLOT};
        4'h1: seq_word = {1'b0, `SEL_DATA, 1'b0, h.dest[6:0]};
        4'h2: seq_word = {1'b0, `SEL_MODE, `HOLD_GRP, 2'h0, `HOLD_CS};
        4'h3: seq_word = {1'b0, `SEL_DATA, h.ctl[7:5], h.dest[11:7]};
        4'h4: seq_word = (h.op == `OP_BREAK) ? {1'b0, `SEL_MODE, `CMD_BREAK}
                                             : {1'b0, `SEL_MODE, `HOLD_GRP, 2'h0, `HOLD_TAG};
        4'h5: seq_word = (h.op == `OP_BREAK) ? {1'b1, `SEL_DATA, `CMD_BREAK}
                                             : {1'b0, `SEL_DATA, h.tag[7:0]};
        4'h6: seq_word = {1'b0, `SEL_MODE, `HOLD_GRP, 2'h0, `HOLD_SUB};
        4'h7: seq_word = {1'b0, `SEL_DATA, h.sub, h.tag[8]};
        4'h8: seq_word = {1'b0, `SEL_MODE, `CMD_MAKE};
        default: seq_word = {1'b1, `SEL_DATA, `CMD_MAKE};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [10:0] sw;
    logic        idle;
    n         = q;
    sw        = seq_word(q);
    idle      = (q.state == H_IDLE);
    n.waitreq = 1'b1;

    // one-cycle answer; the cycle after an answer always waits again
    if ((av_read || av_write) && q.waitreq) begin
      n.waitreq = 1'b0;
      if (av_read) begin
        case (av_address)
          `AV_CTRL: n.readdata = {29'h0, q.op, 1'b0};
          `AV_DEST: n.readdata = {20'h0, q.dest};
          `AV_SRC:  n.readdata = {21'h0, q.src};
          `AV_CTL:  n.readdata = {24'h0, q.ctl};
          `AV_TAG:  n.readdata = {16'h0, q.sub, q.tag};
          `AV_STAT: n.readdata = {22'h0, !idle, q.done, q.stat};
          default:  n.readdata = 32'h0;
        endcase
      end else if (idle) begin
        // fields are frozen while a sequence runs
        case (av_address)
          `AV_CTRL: begin
            if (av_writedata[0]) begin
              n.op    = av_writedata[2:1];
              n.step  = 4'h0;
              n.done  = 1'b0;
              n.state = H_RUN;
            end
          end
          `AV_DEST: n.dest = av_writedata[11:0];
          `AV_SRC:  n.src  = av_writedata[10:0];
          `AV_CTL:  n.ctl  = av_writedata[7:0];
          `AV_TAG: begin
            n.tag = av_writedata[8:0];
            n.sub = av_writedata[15:9];
          end
          default: ;
        endcase
      end
    end

    case (q.state)
      H_IDLE: begin
        n.wr = 1'b0;
        n.rd = 1'b0;
      end
      H_RUN: begin
        n.wr    = 1'b1;
        n.sel   = sw[9:8];
        n.wdata = sw[7:0];
        n.step  = 4'(q.step + 4'h1);
        if (sw[10]) begin
          n.state = H_RD;
        end
      end
      H_RD: begin
        n.wr    = 1'b0;
        n.rd    = 1'b1;
        n.sel   = `SEL_STAT;
        n.state = H_CAP;
      end
      H_CAP: begin
        n.rd    = 1'b0;
        n.state = H_GET;
      end
      H_GET: begin
        n.stat  = dif.rdata;
        n.done  = 1'b1;
        n.state = H_IDLE;
      end
      default: n.state = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q         <= '0;
      q.waitreq <= 1'b1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign av_readdata    = q.readdata;
  assign av_waitrequest = q.waitreq;
  assign dif.wr         = q.wr;
  assign dif.rd         = q.rd;
  assign dif.sel        = q.sel;
  assign dif.wdata      = q.wdata;

endmodule // tsi_conn_host

/* hw/tsi_if.sv */
`timescale 1ns/1ns
interface tsi_if;
  logic       wr;
  logic       rd;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport dev  (input wr, rd, sel, wdata, output rdata);
  modport host (output wr, rd, sel, wdata, input rdata);
endinterface

/* hw/tsi_params.svh */
`ifndef TSI_PARAMS_SVH
`define TSI_PARAMS_SVH
// register selects on the host link
`define SEL_LOW   2'h0
`define SEL_MODE  2'h1
`define SEL_DATA  2'h2
`define SEL_STAT  2'h3
// address-mode register upper nibble: field or holding group
`define FLD_LO    4'h4
`define FLD_HI    4'h5
`define HOLD_GRP  4'hB
// holding register numbers in the low bits of the address-mode register
`define HOLD_SLOT 2'h0
`define HOLD_CS   2'h1
`define HOLD_TAG  2'h2
`define HOLD_SUB  2'h3
// connection block commands
`define CMD_MAKE  8'hE0
`define CMD_BREAK 8'hE1
`define CMD_QLO   8'hE2
`define CMD_QHI   8'hE3
// stream rates and highest valid slot code
`define RATE_2M   2'h0
`define RATE_4M   2'h1
`define RATE_8M   2'h2
`define MAX_2M    7'h1F
`define MAX_4M    7'h3F
`define MAX_8M    7'h7F
// control bits of the second transfer
`define B_AUX     7
`define B_PAT     6
`define B_ALT     5
`define B_ENA     4
// host avalon byte offsets
`define AV_CTRL   5'h00
`define AV_DEST   5'h04
`define AV_SRC    5'h08
`define AV_CTL    5'h0C
`define AV_TAG    5'h10
`define AV_STAT   5'h14
// host operations
`define OP_LOCAL  2'h0
`define OP_MAKE   2'h1
`define OP_BREAK  2'h2
`endif

/* hw/tsi_pkg.sv */
package tsi_pkg;
  typedef struct packed {
    logic       aux;
    logic       pat;
    logic       alt;
    logic       ena;
    logic [3:0] strm;
    logic [6:0] slot;
  } lcl_ent_s;

  typedef struct packed {
    logic       v;
    logic [6:0] slot;
    logic [4:0] strm;
    logic       rw;
    logic       pat;
    logic       alt;
    logic [8:0] tag;
    logic [6:0] sub;
  } cam_ent_s;

  typedef struct packed {
    logic [7:0]              low_addr;
    logic [7:0]              mode;
    logic [7:0]              lo_hold;
    logic [7:0]              h_slot;
    logic [7:0]              h_cs;
    logic [7:0]              h_tag;
    logic [7:0]              h_sub;
    lcl_ent_s [1023:0]       cmem;
    cam_ent_s [511:0]        assoc_connection_block;
    cam_ent_s                qword;
    logic                    rd_hi;
    logic [7:0]              rdata;
    logic                    err;
    logic                    aux;
    logic                    oe;
    logic                    bufsel;
    logic                    pat;
    logic [7:0]              patb;
    logic [9:0]              dm_addr;
    logic [7:0]              line;
    logic                    hit;
    logic                    cdir;
    logic                    cpat;
    logic                    cbuf;
    logic [8:0]              ctag;
    logic                    full;
  } dev_s;

  typedef enum logic [2:0] {H_IDLE, H_RUN, H_RD, H_CAP, H_GET} host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [1:0]  op;
    logic [11:0] dest;
    logic [10:0] src;
    logic [7:0]  ctl;
    logic [8:0]  tag;
    logic [6:0]  sub;
    logic [3:0]  step;
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [7:0]  wdata;
    logic [7:0]  stat;
    logic        done;
    logic        waitreq;
    logic [31:0] readdata;
  } host_s;
endpackage

/* verif/tb_top.sv */
`timescale 1ns/1ns
`include "tsi_params.svh"
module tb_top import tsi_pkg::*;;
  logic        sys_clk, resetn, av_read, av_write, av_waitrequest;
  logic [4:0]  av_address, bus_stream;
  logic [31:0] av_writedata, av_readdata, rdv;
  logic [1:0]  rate_sel;
  logic        slot_tick, bus_tick, line_oe, line_buf_sel, aux_strobe;
  logic [9:0]  cur_addr, dm_addr, pa;
  logic [7:0]  dm_data, line_data;
  logic [6:0]  bus_slot;
  logic        cam_hit, cam_write, cam_pattern, cam_buf_sel, cam_full, cfg_err;
  logic [8:0]  cam_tag;
  int          failures, n_tests, cyc;
  // local cases: rate, destination, source, control, error expected
  logic [1:0]  rt [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
  logic [10:0] dt [5] = '{11'h19D, 11'h2FF, 11'h13F, 11'h0A0, 11'h09F};
  logic [10:0] sr [5] = '{11'h707, 11'h0A5, 11'h4A0, 11'h707, 11'h203};
  logic [7:0]  ct [5] = '{8'h10, 8'hD0, 8'h20, 8'h10, 8'h90};
  logic [4:0]  er = 5'b01000;

  tsi_if tsi_if_i ();
  tsi_conn_host tsi_conn_host_i (.sys_clk, .resetn, .av_address, .av_read, .av_write,
    .av_writedata, .av_readdata, .av_waitrequest, .dif(tsi_if_i));
  tsi_conn_dev tsi_conn_dev_i (.sys_clk, .resetn, .dif(tsi_if_i), .rate_sel, .slot_tick,
    .cur_addr, .dm_addr, .dm_data, .line_data, .line_oe, .line_buf_sel, .aux_strobe,
    .bus_tick, .bus_stream, .bus_slot, .cam_hit, .cam_write, .cam_pattern, .cam_buf_sel,
    .cam_tag, .cam_full, .cfg_err);
  tsi_checker tsi_checker_i (.sys_clk, .resetn, .wr(tsi_if_i.wr), .rd(tsi_if_i.rd),
    .sel(tsi_if_i.sel), .wdata(tsi_if_i.wdata), .slot_tick, .bus_tick, .line_oe, .dm_addr,
    .aux_strobe, .cam_hit, .cam_tag, .cfg_err);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, well above the fill loop's length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon cycle; request held until waitrequest is seen low
  // no answer time is assumed; a hung wait is ended by the cycle guard only
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    av_address <= a;
    av_writedata <= d;
    av_write <= w;
    av_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (av_waitrequest !== 1'b0);
    rdv = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
  endtask

  task automatic op(input logic [1:0] o, input logic [11:0] dst, input logic [10:0] src,
                    input logic [7:0] ctl, input logic [15:0] tag, input logic err);
    int n;
    av(1'b1, `AV_DEST, 32'(dst));
    av(1'b1, `AV_SRC, 32'(src));
    av(1'b1, `AV_CTL, 32'(ctl));
    av(1'b1, `AV_TAG, 32'(tag));
    av(1'b1, `AV_CTRL, 32'({o, 1'b1}));
    n = 0;
    do begin
      av(1'b0, `AV_STAT, 32'h0);
      n++;
    end while (rdv[8] !== 1'b1 && n < 40);
    chk(32'(rdv[9:7]), 32'({2'b01, err}));
  endtask

  task automatic tick(input logic [9:0] a);
    @(posedge sys_clk);
    slot_tick <= 1'b1;
    cur_addr <= a;
    dm_data <= a[7:0] ^ 8'h5A;
    @(posedge sys_clk);
    slot_tick <= 1'b0;
    #1;
  endtask

  task automatic bt(input logic [4:0] s, input logic [6:0] t);
    @(posedge sys_clk);
    bus_tick <= 1'b1;
    bus_stream <= s;
    bus_slot <= t;
    @(posedge sys_clk);
    bus_tick <= 1'b0;
    #1;
  endtask

  function automatic logic [9:0] phys(input logic [1:0] r, input logic [10:0] a);
    case (r)
      2'h0: return {1'b0, a[10:7], a[4:0]};
      2'h1: return {a[10:7], a[5:0]};
      default: return {a[9:7], a[6:0]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, av_read, av_write, slot_tick, bus_tick, failures, n_tests, cyc} = '0;
    {av_address, av_writedata, cur_addr, dm_data, bus_stream, bus_slot} = '0;
    rate_sel = 2'h2;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    av(1'b0, 5'h1C, 32'h0);
    chk(rdv, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rate_sel <= rt[i];
      op(`OP_LOCAL, 12'(dt[i]), sr[i], ct[i], 16'h0, er[i]);
      if (!er[i]) begin
        pa = phys(rt[i], dt[i]);
        tick(pa);
        chk(32'(line_oe), 32'(ct[i][4]));
        chk(32'(line_buf_sel), 32'(ct[i][5]));
        if (!ct[i][6]) chk(32'(dm_addr), 32'(phys(rt[i], sr[i])));
        @(posedge sys_clk);
        #1;
        if (ct[i][4]) chk(32'(line_data), ct[i][6] ? 32'(sr[i][7:0]) : 32'(pa[7:0] ^ 8'h5A));
        tick(pa - 10'h1);
        chk(32'(aux_strobe), 32'(ct[i][7]));
      end
    end
    rate_sel <= 2'h2;
    op(`OP_MAKE, {5'd14, 7'h07}, 11'h0, 8'hA0, 16'h0131, 1'b0);
    bt(5'd14, 7'h07);
    chk({cam_hit, cam_write, cam_pattern, cam_buf_sel, cam_tag}, 32'h1B31);
    op(`OP_MAKE, {5'd3, 7'h1D}, 11'h0, 8'h40, 16'h00AB, 1'b0);
    bt(5'd3, 7'h1D);
    chk({cam_hit, cam_write, cam_pattern, cam_buf_sel, cam_tag}, 32'h14AB);
    bt(5'd14, 7'h08);
    chk(32'(cam_hit), 32'h0);
    op(`OP_BREAK, {5'd14, 7'h07}, 11'h0, 8'h0, 16'h0055, 1'b0);
    bt(5'd14, 7'h07);
    chk(32'(cam_hit), 32'h0);
    op(`OP_BREAK, {5'd14, 7'h07}, 11'h0, 8'h0, 16'h0, 1'b1);
    // one entry stands, so 511 more fill the block
    for (int j = 0; j < 511; j++) begin
      op(`OP_MAKE, {5'(j[8:7]) + 5'd16, j[6:0]}, 11'h0, 8'h20, 16'(j), 1'b0);
    end
    // the full flag lags the last fill by a cycle, so its status byte still shows free
    chk(32'(cam_full), 32'h1);
    op(`OP_MAKE, {5'd9, 7'h01}, 11'h0, 8'h20, 16'h0, 1'b1);
    chk(32'(rdv[6]), 32'h1);
    op(`OP_BREAK, {5'd3, 7'h1D}, 11'h0, 8'h0, 16'h0, 1'b0);
    op(`OP_MAKE, {5'd9, 7'h01}, 11'h0, 8'h20, 16'h0077, 1'b0);
    bt(5'd9, 7'h01);
    chk({cam_hit, cam_write, cam_pattern, cam_buf_sel, cam_tag}, 32'h1277);
    print_verdict();
  end
endmodule // tb_top

/* verif/tsi_checker.sv */
`timescale 1ns/1ns
`include "tsi_params.svh"
module tsi_checker (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // link between the ends
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  // device side
  input wire logic       slot_tick,
  input wire logic       bus_tick,
  input wire logic       line_oe,
  input wire logic [9:0] dm_addr,
  input wire logic       aux_strobe,
  input wire logic       cam_hit,
  input wire logic [8:0] cam_tag,
  input wire logic       cfg_err
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic [3:0] strm_q;

  // stream nibble of the latest mode write, so the second field can be compared
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) strm_q <= 4'h0;
    else if (wr && sel == `SEL_MODE) strm_q <= wdata[3:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  a_local_order: assert property (
    wr && sel == `SEL_LOW |=> wr && sel == `SEL_MODE ##1 wr && sel == `SEL_DATA
    ##1 wr && sel == `SEL_MODE ##1 wr && sel == `SEL_DATA ##1 rd && sel == `SEL_STAT)
    else $error("local step order broken");
  a_field_pick: assert property (
    wr && sel == `SEL_LOW |=> wdata[7:4] == `FLD_LO ##2 wdata[7:4] == `FLD_HI)
    else $error("mode field order wrong");
  a_same_stream: assert property (
    wr && sel == `SEL_MODE && wdata[7:4] == `FLD_HI |-> wdata[3:0] == strm_q)
    else $error("second field aimed at another stream");
  a_cmd_echo: assert property (
    wr && sel == `SEL_MODE && wdata[7:4] == 4'hE |=> wr && sel == `SEL_DATA
    && wdata == $past(wdata)) else $error("command byte not echoed");
  a_make_holds: assert property (
    wr && sel == `SEL_MODE && wdata == 8'hB0 |=> wr && sel == `SEL_DATA
    ##1 wr && sel == `SEL_MODE && wdata == 8'hB1 ##1 wr && sel == `SEL_DATA
    ##1 wr && sel == `SEL_MODE && (wdata == 8'hB2 || wdata == `CMD_BREAK))
    else $error("holding writes out of order");
  a_slot_hold: assert property (
    !slot_tick |=> $stable(line_oe) && $stable(dm_addr) && $stable(aux_strobe))
    else $error("slot outputs moved without a tick");
  a_cam_hold: assert property (
    !bus_tick |=> $stable(cam_hit) && $stable(cam_tag))
    else $error("match outputs moved without a tick");
  a_err_clear: assert property (
    rd && sel == `SEL_STAT && !wr |=> !cfg_err)
    else $error("error flag survived status read");
endmodule // tsi_checker
